// file: dppm_pkg.sv
// shared constants for the decoder phase pin mux
package dppm_pkg;
   localparam int PIN_COUNT = 2;
   // port c pull-up register bit positions
   localparam int PULLUP_BIT_A = 0;
   localparam int PULLUP_BIT_B = 1;
   localparam logic [1:0] PULLUP_RESET = 2'h3;
   // reset values of the per-pin select controls
   localparam logic [1:0] PERIPH_SEL_RESET = 2'h3;
   localparam logic [1:0] ALT_SEL_RESET = 2'h0;
   localparam logic [1:0] GPIO_DIR_RESET = 2'h0;
   localparam logic [1:0] GPIO_OUT_RESET = 2'h0;
   localparam logic [1:0] TIMER_SEL_RESET = 2'h0;
   typedef enum {
      DPPM_FN_DECODER,
      DPPM_FN_TIMER,
      DPPM_FN_SPI,
      DPPM_FN_GPIO,
      DPPM_FN_NONE
   } dppm_fn_type;
endpackage

// file: dppm_pin_mux.sv
// pin multiplexer for the two decoder-one phase pins
// Notes on behaviour
// - full variant: pin A resets to phase A
// - full variant: pin B resets to phase B
// - reduced variant: reset selection is unusable
// - pin A feeds decoder phase A input
// - alternates: pin A timer ch0, B ch1
// - alternate bit A selects SPI clock
// - alternate bit B selects SPI data out
// - clock output as master, input as slave
// - data output as master, input as slave
// - data leads sampling edge by half period
// - each port C line has own direction
// - pull-up A on from reset, bit 0
// - pull-up B on from reset, bit 1
`timescale 1ns/1ps
module dppm_pin_mux import dppm_pkg::*; #(
   parameter bit FULL_VARIANT = 1'b1
) (
   input wire logic clk,
   input wire logic srst,
   // pad side, output enables active low
   input wire logic pinAIn,
   input wire logic pinBIn,
   output logic pinAOut,
   output logic pinAOeN,
   output logic pinBOut,
   output logic pinBOeN,
   output logic pinAPullupEn,
   output logic pinBPullupEn,
   // controls from software-written registers
   input wire logic [1:0] peripheralSelect,
   input wire logic [1:0] timerSelect,
   input wire logic phaseAAlternateSelect,
   input wire logic phaseBAlternateSelect,
   input wire logic [1:0] portCPullupRegister,
   input wire logic [1:0] portCDirection,
   input wire logic [1:0] portCDataOut,
   input wire logic spiMasterMode,
   // peripheral side
   output logic decoderOnePhaseAInput,
   output logic decoderOnePhaseBInput,
   input wire logic timerBChannelZeroOut,
   input wire logic timerBChannelZeroOe,
   output logic timerBChannelZeroIn,
   input wire logic timerBChannelOneOut,
   input wire logic timerBChannelOneOe,
   output logic timerBChannelOneIn,
   input wire logic secondSpiSerialClockOut,
   output logic secondSpiSerialClockIn,
   input wire logic secondSpiMasterOutLineOut,
   output logic secondSpiMasterOutLineIn,
   output logic [1:0] portCLineIn,
   output logic pinAFunctionUsable,
   output logic pinBFunctionUsable
);
   logic [2:0] syncA_reg, syncA_next;
   logic [2:0] syncB_reg, syncB_next;
   logic pinAState_reg, pinAState_next;
   logic pinBState_reg, pinBState_next;
   logic [1:0] periphSel_reg, periphSel_next;
   logic [1:0] altSel_reg, altSel_next;
   logic [1:0] timerSel_reg, timerSel_next;
   logic [1:0] pullup_reg, pullup_next;
   logic [1:0] gpioDir_reg, gpioDir_next;
   logic [1:0] gpioOut_reg, gpioOut_next;
   logic master_reg, master_next;
   logic pinAOut_reg, pinAOut_next, pinAOeN_reg, pinAOeN_next;
   logic pinBOut_reg, pinBOut_next, pinBOeN_reg, pinBOeN_next;
   logic [7:0] fanIn_reg, fanIn_next;
   logic [1:0] usable_reg, usable_next;
   dppm_fn_type fnA, fnB;

   // function chosen for one pin
   function automatic dppm_fn_type pickFn(input logic periph, input logic alt,
                                          input logic tmr);
      if (!periph) begin
         pickFn = DPPM_FN_GPIO;
      end else if (alt) begin
         pickFn = DPPM_FN_SPI;
      end else if (tmr) begin
         pickFn = DPPM_FN_TIMER;
      end else if (FULL_VARIANT) begin
         pickFn = DPPM_FN_DECODER;
      end else begin
         pickFn = DPPM_FN_NONE;
      end
   endfunction

   always_comb begin
      fnA = pickFn(periphSel_reg[0], altSel_reg[0], timerSel_reg[0]);
      fnB = pickFn(periphSel_reg[1], altSel_reg[1], timerSel_reg[1]);
   end

   // control registers and pad synchronisers
   always_comb begin
      syncA_next = {syncA_reg[1:0], pinAIn};
      syncB_next = {syncB_reg[1:0], pinBIn};
      pinAState_next = (syncA_reg[1] == syncA_reg[2]) ? syncA_reg[2] : pinAState_reg;
      pinBState_next = (syncB_reg[1] == syncB_reg[2]) ? syncB_reg[2] : pinBState_reg;
      periphSel_next = peripheralSelect;
      altSel_next = {phaseBAlternateSelect, phaseAAlternateSelect};
      timerSel_next = timerSelect;
      pullup_next = portCPullupRegister;
      gpioDir_next = portCDirection;
      gpioOut_next = portCDataOut;
      master_next = spiMasterMode;
   end

   // pad drive and peripheral-side fan-in
   always_comb begin
      pinAOut_next = 1'b0;
      pinAOeN_next = 1'b1;
      pinBOut_next = 1'b0;
      pinBOeN_next = 1'b1;
      fanIn_next = 8'h00;
      case (fnA)
         DPPM_FN_DECODER: fanIn_next[0] = pinAState_reg;
         DPPM_FN_TIMER: begin
            fanIn_next[2] = pinAState_reg;
            pinAOut_next = timerBChannelZeroOut;
            pinAOeN_next = !timerBChannelZeroOe;
         end
         DPPM_FN_SPI: begin
            if (master_reg) begin
               pinAOut_next = secondSpiSerialClockOut;
               pinAOeN_next = 1'b0;
            end else begin
               fanIn_next[4] = pinAState_reg;
            end
         end
         DPPM_FN_GPIO: begin
            fanIn_next[6] = pinAState_reg;
            pinAOut_next = gpioOut_reg[0];
            pinAOeN_next = !gpioDir_reg[0];
         end
         default: ;
      endcase
      case (fnB)
         DPPM_FN_DECODER: fanIn_next[1] = pinBState_reg;
         DPPM_FN_TIMER: begin
            fanIn_next[3] = pinBState_reg;
            pinBOut_next = timerBChannelOneOut;
            pinBOeN_next = !timerBChannelOneOe;
         end
         DPPM_FN_SPI: begin
            if (master_reg) begin
               // data path delay equals clock path, keeps half-period lead
               pinBOut_next = secondSpiMasterOutLineOut;
               pinBOeN_next = 1'b0;
            end else begin
               fanIn_next[5] = pinBState_reg;
            end
         end
         DPPM_FN_GPIO: begin
            fanIn_next[7] = pinBState_reg;
            pinBOut_next = gpioOut_reg[1];
            pinBOeN_next = !gpioDir_reg[1];
         end
         default: ;
      endcase
      usable_next = {fnB != DPPM_FN_NONE, fnA != DPPM_FN_NONE};
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         syncA_reg <= 3'h7;
         syncB_reg <= 3'h7;
         pinAState_reg <= 1'b1;
         pinBState_reg <= 1'b1;
         periphSel_reg <= PERIPH_SEL_RESET;
         altSel_reg <= ALT_SEL_RESET;
         timerSel_reg <= TIMER_SEL_RESET;
         pullup_reg <= PULLUP_RESET;
         gpioDir_reg <= GPIO_DIR_RESET;
         gpioOut_reg <= GPIO_OUT_RESET;
         master_reg <= 1'b0;
         pinAOut_reg <= 1'b0;
         pinAOeN_reg <= 1'b1;
         pinBOut_reg <= 1'b0;
         pinBOeN_reg <= 1'b1;
         fanIn_reg <= 8'h00;
         usable_reg <= 2'h0;
      end else begin
         syncA_reg <= syncA_next;
         syncB_reg <= syncB_next;
         pinAState_reg <= pinAState_next;
         pinBState_reg <= pinBState_next;
         periphSel_reg <= periphSel_next;
         altSel_reg <= altSel_next;
         timerSel_reg <= timerSel_next;
         pullup_reg <= pullup_next;
         gpioDir_reg <= gpioDir_next;
         gpioOut_reg <= gpioOut_next;
         master_reg <= master_next;
         pinAOut_reg <= pinAOut_next;
         pinAOeN_reg <= pinAOeN_next;
         pinBOut_reg <= pinBOut_next;
         pinBOeN_reg <= pinBOeN_next;
         fanIn_reg <= fanIn_next;
         usable_reg <= usable_next;
      end
   end

   always_comb begin
      pinAOut = pinAOut_reg;
      pinAOeN = pinAOeN_reg;
      pinBOut = pinBOut_reg;
      pinBOeN = pinBOeN_reg;
      pinAPullupEn = pullup_reg[PULLUP_BIT_A];
      pinBPullupEn = pullup_reg[PULLUP_BIT_B];
      decoderOnePhaseAInput = fanIn_reg[0];
      decoderOnePhaseBInput = fanIn_reg[1];
      timerBChannelZeroIn = fanIn_reg[2];
      timerBChannelOneIn = fanIn_reg[3];
      secondSpiSerialClockIn = fanIn_reg[4];
      secondSpiMasterOutLineIn = fanIn_reg[5];
      portCLineIn = fanIn_reg[7:6];
      pinAFunctionUsable = usable_reg[0];
      pinBFunctionUsable = usable_reg[1];
   end

   pull_a_a: assert property (@(posedge clk) disable iff (srst)
      !portCPullupRegister[0] |=> !pinAPullupEn)
      else $error("pin A pull-up not released");
   pull_b_a: assert property (@(posedge clk) disable iff (srst)
      portCPullupRegister[1] |=> pinBPullupEn)
      else $error("pin B pull-up wrong");
   spi_clk_a: assert property (@(posedge clk) disable iff (srst)
      (fnA == DPPM_FN_SPI && master_reg) |=>
         (!pinAOeN && pinAOut == $past(secondSpiSerialClockOut)))
      else $error("spi clock not driven as master");
   spi_data_a: assert property (@(posedge clk) disable iff (srst)
      (fnB == DPPM_FN_SPI && !master_reg) |=> pinBOeN)
      else $error("spi data driven as slave");
   dec_route_a: assert property (@(posedge clk) disable iff (srst)
      (fnA == DPPM_FN_DECODER) |=> decoderOnePhaseAInput == $past(pinAState_reg))
      else $error("decoder phase A not routed");
   gpio_dir_a: assert property (@(posedge clk) disable iff (srst)
      (fnB == DPPM_FN_GPIO) |=> pinBOeN == !$past(gpioDir_reg[1]))
      else $error("port C line one direction wrong");
   timer_a: assert property (@(posedge clk) disable iff (srst)
      (fnA == DPPM_FN_TIMER && timerBChannelZeroOe) |=> !pinAOeN)
      else $error("timer channel zero not driven");
   reset_fn_a: assert property (@(posedge clk)
      $fell(srst) |-> (fnA == (FULL_VARIANT ? DPPM_FN_DECODER : DPPM_FN_NONE)))
      else $error("pin A reset function wrong");
   reset_fnb_a: assert property (@(posedge clk)
      $fell(srst) |-> (fnB == (FULL_VARIANT ? DPPM_FN_DECODER : DPPM_FN_NONE)))
      else $error("pin B reset function wrong");
   alt_a: assert property (@(posedge clk) disable iff (srst)
      (periphSel_reg[1] && altSel_reg[1] && master_reg) |=>
         (!pinBOeN && pinBOut == $past(secondSpiMasterOutLineOut)))
      else $error("alternate B not SPI data out");
endmodule // dppm_pin_mux

// file: dppm_far_end.sv
// far-side pad model: encoder, spi peer or timer signal on both pins
`timescale 1ns/1ps
module dppm_far_end (
   input wire logic clk,
   input wire logic [1:0] farDrive,
   input wire logic [1:0] farValue,
   input wire logic [1:0] padOut,
   input wire logic [1:0] padOeN,
   input wire logic [1:0] pullupEn,
   output logic [1:0] padLevel
);
   logic [1:0] lastLevel_reg;
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (!padOeN[i]) begin
            padLevel[i] = padOut[i];
         end else if (farDrive[i]) begin
            padLevel[i] = farValue[i];
         end else if (pullupEn[i]) begin
            padLevel[i] = 1'b1;
         end else begin
            padLevel[i] = ~lastLevel_reg[i];
         end
      end
   end
   always_ff @(posedge clk) begin
      lastLevel_reg <= padLevel;
   end
endmodule // dppm_far_end

// file: decoder_phase_pin_mux_tb.sv
// self-checking testbench for the decoder phase pin mux
`timescale 1ns/1ps
module decoder_phase_pin_mux_tb;
   import dppm_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   wire logic pinAIn, pinBIn;
   logic pinAOut, pinAOeN, pinBOut, pinBOeN, pinAPullupEn, pinBPullupEn;
   logic [1:0] peripheralSelect = PERIPH_SEL_RESET;
   logic [1:0] timerSelect = TIMER_SEL_RESET;
   logic phaseAAlternateSelect = 1'b0, phaseBAlternateSelect = 1'b0, spiMasterMode = 1'b0;
   logic [1:0] portCPullupRegister = PULLUP_RESET, portCDirection = GPIO_DIR_RESET;
   logic [1:0] portCDataOut = GPIO_OUT_RESET, farDrive = 2'h0, farValue = 2'h0;
   logic decoderOnePhaseAInput, decoderOnePhaseBInput, timerBChannelZeroIn, timerBChannelOneIn;
   logic timerBChannelZeroOut = 1'b0, timerBChannelZeroOe = 1'b0;
   logic timerBChannelOneOut = 1'b0, timerBChannelOneOe = 1'b0;
   logic secondSpiSerialClockOut = 1'b0, secondSpiMasterOutLineOut = 1'b0;
   logic secondSpiSerialClockIn, secondSpiMasterOutLineIn, pinAFunctionUsable, pinBFunctionUsable;
   logic [1:0] portCLineIn;
   logic redUsableA, redUsableB, redPhaseA, redOeNA;
   int failCount = 0;
   int comparisons = 0;
   always #5 clk = ~clk;
   dppm_pin_mux #(.FULL_VARIANT(1'b1)) DUT (.clk(clk), .srst(srst), .pinAIn(pinAIn),
      .pinBIn(pinBIn), .pinAOut(pinAOut), .pinAOeN(pinAOeN), .pinBOut(pinBOut),
      .pinBOeN(pinBOeN), .pinAPullupEn(pinAPullupEn), .pinBPullupEn(pinBPullupEn),
      .peripheralSelect(peripheralSelect), .timerSelect(timerSelect),
      .phaseAAlternateSelect(phaseAAlternateSelect),
      .phaseBAlternateSelect(phaseBAlternateSelect),
      .portCPullupRegister(portCPullupRegister), .portCDirection(portCDirection),
      .portCDataOut(portCDataOut), .spiMasterMode(spiMasterMode),
      .decoderOnePhaseAInput(decoderOnePhaseAInput),
      .decoderOnePhaseBInput(decoderOnePhaseBInput),
      .timerBChannelZeroOut(timerBChannelZeroOut), .timerBChannelZeroOe(timerBChannelZeroOe),
      .timerBChannelZeroIn(timerBChannelZeroIn), .timerBChannelOneOut(timerBChannelOneOut),
      .timerBChannelOneOe(timerBChannelOneOe), .timerBChannelOneIn(timerBChannelOneIn),
      .secondSpiSerialClockOut(secondSpiSerialClockOut),
      .secondSpiSerialClockIn(secondSpiSerialClockIn),
      .secondSpiMasterOutLineOut(secondSpiMasterOutLineOut),
      .secondSpiMasterOutLineIn(secondSpiMasterOutLineIn),
      .portCLineIn(portCLineIn), .pinAFunctionUsable(pinAFunctionUsable),
      .pinBFunctionUsable(pinBFunctionUsable));
   // reduced variant watches the same pads, drives none
   dppm_pin_mux #(.FULL_VARIANT(1'b0)) reducedDut (.clk(clk), .srst(srst), .pinAIn(pinAIn),
      .pinBIn(pinBIn), .pinAOut(), .pinAOeN(redOeNA), .pinBOut(), .pinBOeN(),
      .pinAPullupEn(), .pinBPullupEn(),
      .peripheralSelect(peripheralSelect), .timerSelect(timerSelect),
      .phaseAAlternateSelect(phaseAAlternateSelect),
      .phaseBAlternateSelect(phaseBAlternateSelect),
      .portCPullupRegister(portCPullupRegister), .portCDirection(portCDirection),
      .portCDataOut(portCDataOut), .spiMasterMode(spiMasterMode),
      .decoderOnePhaseAInput(redPhaseA), .decoderOnePhaseBInput(),
      .timerBChannelZeroOut(timerBChannelZeroOut), .timerBChannelZeroOe(timerBChannelZeroOe),
      .timerBChannelZeroIn(), .timerBChannelOneOut(timerBChannelOneOut),
      .timerBChannelOneOe(timerBChannelOneOe), .timerBChannelOneIn(),
      .secondSpiSerialClockOut(secondSpiSerialClockOut), .secondSpiSerialClockIn(),
      .secondSpiMasterOutLineOut(secondSpiMasterOutLineOut), .secondSpiMasterOutLineIn(),
      .portCLineIn(), .pinAFunctionUsable(redUsableA), .pinBFunctionUsable(redUsableB));
   dppm_far_end farEnd (.clk(clk), .farDrive(farDrive), .farValue(farValue),
      .padOut({pinBOut, pinAOut}), .padOeN({pinBOeN, pinAOeN}),
      .pullupEn({pinBPullupEn, pinAPullupEn}), .padLevel({pinBIn, pinAIn}));
   task automatic settle();
      repeat (10) @(negedge clk);
   endtask
   task automatic chk(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp) begin
         failCount++;
         $display("ERROR %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask
   task automatic endSim();
      $display("comparisons %0d, mismatches %0d", comparisons, failCount);
      if (failCount == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic testResetDefaults();
      chk(pinAPullupEn, 1'b1, "pull-up A");
      chk(pinBPullupEn, 1'b1, "pull-up B");
      chk(pinAOeN, 1'b1, "pin A undriven");
      chk(pinBOeN, 1'b1, "pin B undriven");
      farDrive = 2'h3;
      farValue = 2'h1;
      settle();
      chk(decoderOnePhaseAInput, 1'b1, "phase A high");
      chk(decoderOnePhaseBInput, 1'b0, "phase B low");
      chk(pinAFunctionUsable, 1'b1, "usable A");
      chk(pinBFunctionUsable, 1'b1, "usable B");
      chk(redUsableA, 1'b0, "reduced A unusable");
      chk(redUsableB, 1'b0, "reduced B unusable");
      chk(redPhaseA, 1'b0, "reduced phase A idle");
      chk(redOeNA, 1'b1, "reduced pin A undriven");
      farValue = 2'h2;
      settle();
      chk(decoderOnePhaseAInput, 1'b0, "phase A low");
      chk(decoderOnePhaseBInput, 1'b1, "phase B high");
   endtask
   task automatic testTimer();
      timerSelect = 2'h3;
      timerBChannelZeroOe = 1'b1;
      timerBChannelZeroOut = 1'b1;
      farValue = 2'h2;
      settle();
      chk(pinAOeN, 1'b0, "timer 0 drives");
      chk(pinAOut, 1'b1, "timer 0 value");
      chk(timerBChannelZeroIn, 1'b1, "timer 0 readback");
      chk(pinBOeN, 1'b1, "timer 1 released");
      chk(timerBChannelOneIn, 1'b1, "timer 1 input");
      chk(redUsableA, 1'b1, "reduced A reprogrammed");
      chk(redUsableB, 1'b1, "reduced B reprogrammed");
      chk(decoderOnePhaseAInput, 1'b0, "decoder idle");
   endtask
   task automatic testSpi();
      phaseAAlternateSelect = 1'b1;
      phaseBAlternateSelect = 1'b1;
      spiMasterMode = 1'b1;
      secondSpiSerialClockOut = 1'b1;
      farDrive = 2'h0;
      settle();
      chk(pinAOeN, 1'b0, "clock drives");
      chk(pinAOut, 1'b1, "clock value");
      chk(pinBOeN, 1'b0, "data drives");
      chk(pinBOut, 1'b0, "data value");
      secondSpiSerialClockOut = 1'b0;
      secondSpiMasterOutLineOut = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(pinAOut, 1'b0, "clock path delay");
      chk(pinBOut, 1'b1, "data path delay");
      @(negedge clk);
      spiMasterMode = 1'b0;
      farDrive = 2'h3;
      farValue = 2'h3;
      settle();
      chk(pinAOeN, 1'b1, "slave clock input");
      chk(pinBOeN, 1'b1, "slave data input");
      chk(secondSpiSerialClockIn, 1'b1, "clock in");
      chk(secondSpiMasterOutLineIn, 1'b1, "data in");
   endtask
   task automatic testGpio();
      peripheralSelect = 2'h0;
      portCDirection = 2'h1;
      portCDataOut = 2'h1;
      portCPullupRegister = 2'h0;
      farDrive = 2'h2;
      farValue = 2'h0;
      settle();
      chk(pinAOeN, 1'b0, "line 0 output");
      chk(pinAOut, 1'b1, "line 0 value");
      chk(portCLineIn[0], 1'b1, "line 0 readback");
      chk(pinBOeN, 1'b1, "line 1 input");
      chk(portCLineIn[1], 1'b0, "line 1 low");
      chk(pinAPullupEn, 1'b0, "pull-up A off");
      chk(pinBPullupEn, 1'b0, "pull-up B off");
      farValue = 2'h2;
      srst = 1'b1;
      settle();
      chk(pinAPullupEn, 1'b1, "pull-up A in reset");
      chk(pinBOeN, 1'b1, "pin B in reset");
      srst = 1'b0;
      settle();
      chk(portCLineIn[1], 1'b1, "line 1 high");
   endtask
   initial begin
      repeat (16) @(negedge clk);
      srst = 1'b0;
      settle();
      testResetDefaults();
      testTimer();
      testSpi();
      testGpio();
      endSim();
   end
   initial begin
      repeat (5000) @(posedge clk);
      failCount++;
      endSim();
   end
endmodule // decoder_phase_pin_mux_tb
